// File: design/sslc_codec.sv
// module: switch state link encoder and decoder, sharing one packet format
`timescale 1ns/100ps
module sslc_codec #(
  parameter int unsigned BIT_SLOW = sslc_pkg::BIT_CYC_LOW,
  parameter int unsigned BIT_FAST = sslc_pkg::BIT_CYC_HIGH,
  parameter int unsigned HOLD_CYC = sslc_pkg::HOLD_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic enc_rate_fast_in,
  input wire logic [3:0] enc_switch_lines_in,
  output logic enc_serial_out,
  output logic enc_awake_out,
  input wire logic dec_rate_fast_in,
  input wire logic dec_serial_in,
  output logic [3:0] dec_switch_lines_out,
  output logic dec_awake_out
);
  // ----------------------------------------------------------------
  // encoder state
  // ----------------------------------------------------------------
  typedef enum {SSLC_SLEEP, SSLC_SEND} sslc_enc_state_type;
  sslc_enc_state_type enc_state, next_enc_state; // sleep or sending
  logic [15:0] enc_cnt, next_enc_cnt; // bit period counter
  logic [3:0] enc_idx, next_enc_idx; // bit being sent
  logic [10:0] enc_pkt, next_enc_pkt; // frame under way
  logic enc_line, next_enc_line; // registered serial line
  logic [15:0] enc_per; // period from rate pin
  logic any_high; // some switch input high
  assign enc_per = enc_rate_fast_in ? 16'(BIT_FAST) : 16'(BIT_SLOW);
  assign any_high = |enc_switch_lines_in;
  // builds a frame from fresh samples; data duplicated inverted for checking
  function automatic logic [10:0] sslc_frame(input logic [3:0] d);
    sslc_frame = {2'b00, ~d, d, 1'b1};
  endfunction
  // ----------------------------------------------------------------
  // encoder next state
  // ----------------------------------------------------------------
  always_comb begin
    next_enc_state = enc_state;
    next_enc_cnt = enc_cnt;
    next_enc_idx = enc_idx;
    next_enc_pkt = enc_pkt;
    next_enc_line = 1'b0;
    case (enc_state)
      SSLC_SLEEP: begin
        // wake on any input; the line stays low while asleep
        if (any_high) begin
          next_enc_state = SSLC_SEND;
          next_enc_pkt = sslc_frame(enc_switch_lines_in);
          next_enc_idx = 4'h0;
          next_enc_cnt = enc_per - 16'h0001;
          next_enc_line = 1'b1;
        end
      end
      SSLC_SEND: begin
        // inputs are not looked at mid-packet, so a frame always completes
        if (enc_cnt != 16'h0000) begin
          next_enc_cnt = enc_cnt - 16'h0001;
          next_enc_line = enc_pkt[enc_idx];
        end else if (enc_idx != 4'(sslc_pkg::PKT_BITS - 1)) begin
          next_enc_idx = enc_idx + 4'h1;
          next_enc_cnt = enc_per - 16'h0001;
          next_enc_line = enc_pkt[enc_idx + 4'h1];
        end else if (any_high) begin
          // back to back: the stop bits just sent give the decoder its low
          next_enc_pkt = sslc_frame(enc_switch_lines_in);
          next_enc_idx = 4'h0;
          next_enc_cnt = enc_per - 16'h0001;
          next_enc_line = 1'b1;
        end else begin
          next_enc_state = SSLC_SLEEP;
        end
      end
      default: next_enc_state = SSLC_SLEEP;
    endcase
  end
  // ----------------------------------------------------------------
  // encoder registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enc_state <= SSLC_SLEEP;
      enc_cnt <= 16'h0000;
      enc_idx <= 4'h0;
      enc_pkt <= 11'h000;
      enc_line <= 1'b0;
    end else begin
      enc_state <= next_enc_state;
      enc_cnt <= next_enc_cnt;
      enc_idx <= next_enc_idx;
      enc_pkt <= next_enc_pkt;
      enc_line <= next_enc_line;
    end
  end
  assign enc_serial_out = enc_line;
  assign enc_awake_out = (enc_state == SSLC_SEND);
  // ----------------------------------------------------------------
  // decoder receiver
  // ----------------------------------------------------------------
  logic rx_good; // pulse: checked packet
  logic [3:0] rx_data; // its data bits
  sslc_rx_frame #(
    .BIT_SLOW(BIT_SLOW),
    .BIT_FAST(BIT_FAST)
  ) u_rx (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .rate_fast_in(dec_rate_fast_in),
    .serial_in(dec_serial_in),
    .good_out(rx_good),
    .data_out(rx_data)
  );
  // ----------------------------------------------------------------
  // decoder output hold
  // ----------------------------------------------------------------
  logic [3:0] outs, next_outs; // held output levels
  logic [24:0] hold, next_hold; // cycles left before timeout
  logic awake, next_awake; // decoder holding outputs
  always_comb begin
    next_outs = outs;
    next_hold = hold;
    next_awake = awake;
    if (rx_good) begin
      // only checked packets reach the pins; same index, same line
      next_outs = rx_data;
      next_hold = 25'(HOLD_CYC - 1);
      next_awake = 1'b1;
    end else if (awake) begin
      if (hold != 25'h0000000) begin
        next_hold = hold - 25'h0000001;
      end else begin
        next_outs = 4'h0;
        next_awake = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      outs <= 4'h0;
      hold <= 25'h0000000;
      awake <= 1'b0;
    end else begin
      outs <= next_outs;
      hold <= next_hold;
      awake <= next_awake;
    end
  end
  assign dec_switch_lines_out = outs;
  assign dec_awake_out = awake;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sleep_quiet;
    @(posedge clk_in) disable iff (!rstn_in)
      (enc_state == SSLC_SLEEP && !any_high) |=> !enc_serial_out;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("line high while asleep");
  property p_wake;
    @(posedge clk_in) disable iff (!rstn_in)
      (enc_state == SSLC_SLEEP && any_high) |=> (enc_serial_out && enc_awake_out);
  endproperty
  a_wake: assert property (p_wake) else $error("no start bit on wake");
  property p_capture;
    @(posedge clk_in) disable iff (!rstn_in)
      (enc_state == SSLC_SLEEP && any_high) |=> (enc_pkt[4:1] == $past(enc_switch_lines_in));
  endproperty
  a_capture: assert property (p_capture) else $error("packet data not sampled");
  property p_finish;
    @(posedge clk_in) disable iff (!rstn_in)
      (enc_awake_out && enc_idx != 4'ha) |=> enc_awake_out;
  endproperty
  a_finish: assert property (p_finish) else $error("packet cut short");
  property p_update_only_good;
    @(posedge clk_in) disable iff (!rstn_in)
      (!rx_good && awake && hold != 25'h0000000) |=> $stable(dec_switch_lines_out);
  endproperty
  a_update_only_good: assert property (p_update_only_good) else $error("outputs moved");
  property p_good_load;
    @(posedge clk_in) disable iff (!rstn_in)
      rx_good |=> (dec_switch_lines_out == $past(rx_data) && dec_awake_out);
  endproperty
  a_good_load: assert property (p_good_load) else $error("good packet not shown");
  property p_timeout;
    @(posedge clk_in) disable iff (!rstn_in)
      (awake && !rx_good && hold == 25'h0000000) |=> (dec_switch_lines_out == 4'h0 && !awake);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not clear");
  property p_asleep_low;
    @(posedge clk_in) disable iff (!rstn_in)
      !dec_awake_out |-> (dec_switch_lines_out == 4'h0);
  endproperty
  a_asleep_low: assert property (p_asleep_low) else $error("outputs high while asleep");
endmodule // sslc_codec

// File: design/sslc_pkg.sv
// package: shared constants for the switch state link encoder and decoder
package sslc_pkg;
  // ----------------------------------------------------------------
  // clock and line rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000; // local clock rate
  localparam int unsigned RATE_LOW_BPS = 2400; // select pin low
  localparam int unsigned RATE_HIGH_BPS = 9600; // select pin high
  localparam int unsigned BIT_CYC_LOW = CLK_HZ / RATE_LOW_BPS; // cycles per bit, slow
  localparam int unsigned BIT_CYC_HIGH = CLK_HZ / RATE_HIGH_BPS; // cycles per bit, fast
  localparam int unsigned DIV_W = 16; // width of the bit divider
  // ----------------------------------------------------------------
  // hold timeout
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_MS = 131; // output hold time in ms
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS; // cycles of hold
  localparam int unsigned HOLD_W = 25; // width of the hold counter
  // ----------------------------------------------------------------
  // packet format: start(1), data(4), inverted data(4), stop(0), stop(0)
  // ----------------------------------------------------------------
  localparam int unsigned LINES = 4; // number of switch lines
  localparam int unsigned PKT_BITS = 11; // bits per packet
  localparam int unsigned PKT_W = 4; // width of a bit index
  localparam logic [10:0] PKT_BIT_START = 11'h001; // start bit mask at index 0
endpackage

// File: design/sslc_rx_frame.sv
// module: packet receiver and checker used by the decoder
`timescale 1ns/100ps
module sslc_rx_frame #(
  parameter int unsigned BIT_SLOW = sslc_pkg::BIT_CYC_LOW,
  parameter int unsigned BIT_FAST = sslc_pkg::BIT_CYC_HIGH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic rate_fast_in,
  input wire logic serial_in,
  output logic good_out,
  output logic [3:0] data_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {SSLC_RX_IDLE, SSLC_RX_BITS} sslc_rx_state_type;
  sslc_rx_state_type state, next_state; // receiver phase
  logic prev_line, next_prev_line; // line level last cycle, for edge find
  logic [15:0] cnt, next_cnt; // bit period counter
  logic [3:0] idx, next_idx; // bit index
  logic [10:0] sh, next_sh; // collected bits
  logic good, next_good; // pulse: packet passed
  logic [3:0] data, next_data; // last passed data
  logic [15:0] per; // bit period chosen by the rate pin
  logic [10:0] full; // packet including the current bit
  assign per = rate_fast_in ? 16'(BIT_FAST) : 16'(BIT_SLOW);
  assign full = sh | (11'(serial_in) << idx);
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_prev_line = serial_in;
    next_cnt = cnt;
    next_idx = idx;
    next_sh = sh;
    next_good = 1'b0;
    next_data = data;
    case (state)
      SSLC_RX_IDLE: begin
        // rising edge marks a start bit; first sample half a bit later
        if (!prev_line && serial_in) begin
          next_state = SSLC_RX_BITS;
          next_cnt = per >> 1;
          next_idx = 4'h0;
          next_sh = 11'h000;
        end
      end
      SSLC_RX_BITS: begin
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else if (idx == 4'(sslc_pkg::PKT_BITS - 1)) begin
          // last bit: check start, stop bits and the inverted copy
          next_state = SSLC_RX_IDLE;
          if (full[0] && !full[9] && !full[10] && (full[4:1] == ~full[8:5])) begin
            next_good = 1'b1;
            next_data = full[4:1];
          end
        end else begin
          next_sh = full;
          next_idx = idx + 4'h1;
          next_cnt = per - 16'h0001;
        end
      end
      default: next_state = SSLC_RX_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= SSLC_RX_IDLE;
      prev_line <= 1'b1;
      cnt <= 16'h0000;
      idx <= 4'h0;
      sh <= 11'h000;
      good <= 1'b0;
      data <= 4'h0;
    end else begin
      state <= next_state;
      prev_line <= next_prev_line;
      cnt <= next_cnt;
      idx <= next_idx;
      sh <= next_sh;
      good <= next_good;
      data <= next_data;
    end
  end
  assign good_out = good;
  assign data_out = data;
endmodule // sslc_rx_frame

// File: tb/sslc_far_end.sv
// far side model: remote decoder of the encoder line, remote encoder for the decoder
`timescale 1ns/100ps
module sslc_far_end #(
  parameter int unsigned BIT_SLOW = 16,
  parameter int unsigned BIT_FAST = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic rate_fast_in,
  input wire logic line_in,
  output logic line_out,
  output logic got_out,
  output logic [3:0] got_data_out
);
  // ----------------------------------------------------------------
  // receiver: rising edge starts a frame, samples at mid bit
  // ----------------------------------------------------------------
  initial begin
    logic [10:0] f; // frame bits, index 0 first on the line
    logic last; // line level one edge ago
    int p; // cycles per bit at the chosen rate
    got_out = 1'b0;
    got_data_out = 4'h0;
    last = 1'b1;
    forever begin
      @(posedge clk_in);
      got_out <= 1'b0;
      if (rstn_in === 1'b1 && line_in === 1'b1 && last === 1'b0) begin
        p = rate_fast_in ? BIT_FAST : BIT_SLOW;
        repeat (p / 2 - 1) @(posedge clk_in);
        for (int k = 0; k < 11; k++) begin
          f[k] = line_in;
          if (k < 10) repeat (p) @(posedge clk_in);
        end
        // a malformed frame reports unknown data so the bench flags it
        if (f[0] === 1'b1 && f[8:5] === ~f[4:1] && f[10:9] === 2'h0) begin
          got_data_out <= f[4:1];
        end else begin
          got_data_out <= 4'hx;
        end
        got_out <= 1'b1;
      end
      last = line_in;
    end
  end
  // ----------------------------------------------------------------
  // transmitter: idle low, bad selects a corrupted frame
  // ----------------------------------------------------------------
  initial line_out = 1'b0;
  task automatic send_frame(input logic [3:0] d, input int bad);
    logic [10:0] f;
    int p;
    f = {2'h0, ~d, d, 1'b1};
    if (bad == 1) f[5] = ~f[5]; // inverse copy broken
    if (bad == 2) f[9] = 1'b1; // stop bit broken
    p = rate_fast_in ? BIT_FAST : BIT_SLOW;
    for (int k = 0; k < 11; k++) begin
      @(posedge clk_in);
      line_out <= f[k];
      repeat (p - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
  endtask
endmodule // sslc_far_end

// File: tb/tb_switch_state_link_codec.sv
// testbench: encoder framing, decoder checking and hold timeout of the codec
`timescale 1ns/100ps
module tb_switch_state_link_codec;
  // ----------------------------------------------------------------
  // signals and scoreboard
  // ----------------------------------------------------------------
  localparam int unsigned SLOW = 16; // short bit periods keep the run brief
  localparam int unsigned FAST = 8;
  localparam int unsigned HOLD = 2000;
  logic clk_in;
  logic rstn_in = 1'b0;
  logic rate = 1'b0; // both ends share one rate
  logic [3:0] sw = 4'h0; // switch lines idle low
  logic enc_line, enc_awake, dec_line, dec_awake, got;
  logic [3:0] dec_lines, got_data;
  logic [3:0] dec_prev = 4'h0;
  logic [3:0] enc_q[$]; // frames expected at the far side
  logic [3:0] dec_q[$]; // decoder output changes expected
  int n_fail = 0;
  int comparisons = 0;
  int seed = 58;
  sslc_codec #(.BIT_SLOW(SLOW), .BIT_FAST(FAST), .HOLD_CYC(HOLD)) sslc_codec_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .enc_rate_fast_in(rate),
    .enc_switch_lines_in(sw), .enc_serial_out(enc_line), .enc_awake_out(enc_awake),
    .dec_rate_fast_in(rate), .dec_serial_in(dec_line),
    .dec_switch_lines_out(dec_lines), .dec_awake_out(dec_awake));
  sslc_far_end #(.BIT_SLOW(SLOW), .BIT_FAST(FAST)) sslc_far_end_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .rate_fast_in(rate), .line_in(enc_line),
    .line_out(dec_line), .got_out(got), .got_data_out(got_data));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_line(input logic lvl);
    int n;
    n = 0;
    while (enc_line !== lvl && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    check("line level", lvl, enc_line);
  endtask
  task automatic wait_got();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (got !== 1'b1 && n < 4000);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // monitors: oldest note against each result seen
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (got === 1'b1) check("far frame", enc_q.size() ? enc_q.pop_front() : 4'hx, got_data);
  end
  always @(posedge clk_in) begin
    if (rstn_in === 1'b1 && dec_lines !== dec_prev) begin
      dec_prev <= dec_lines;
      check("dec lines", dec_q.size() ? dec_q.pop_front() : 4'hx, dec_lines);
    end
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    n_fail++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence, once per rate
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] v, w;
    int p, n;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    check("enc awake", 0, enc_awake);
    check("enc line", 0, enc_line);
    for (int r = 0; r < 2; r++) begin
      rate <= r[0];
      @(posedge clk_in);
      p = r ? FAST : SLOW;
      v = 4'($random(seed));
      v[0] = 1'b0; // lone start bit gives a clean width
      if (v == 4'h0) v = 4'h2;
      w = 4'($random(seed));
      if (w == 4'h0) w = 4'h8;
      enc_q.push_back(v);
      enc_q.push_back(w);
      sw <= v;
      wait_line(1'b1);
      n = 0;
      while (enc_line === 1'b1 && n < 1000) begin
        @(posedge clk_in);
        n++;
      end
      check("start width", p, n);
      wait_got();
      check("first frame seen", 1, got);
      sw <= w; // new levels for the next frame
      wait_line(1'b1);
      sw <= 4'h0; // drop mid frame, frame must finish
      wait_got();
      check("second frame seen", 1, got);
      repeat (2 * p) @(posedge clk_in);
      check("enc asleep", 0, enc_awake);
      check("enc idle", 0, enc_line);
      // decoder: good, two broken, good, then silence
      v = 4'($random(seed));
      if (v == 4'h0) v = 4'h5;
      w = (v == 4'hf) ? 4'h1 : v + 4'h1;
      dec_q.push_back(v);
      sslc_far_end_inst.send_frame(v, 0);
      sslc_far_end_inst.send_frame(~v, 1);
      sslc_far_end_inst.send_frame(~v, 2);
      check("dec held", v, dec_lines);
      check("dec awake", 1, dec_awake);
      dec_q.push_back(w);
      dec_q.push_back(4'h0);
      sslc_far_end_inst.send_frame(w, 0);
      n = 0;
      while (dec_lines !== 4'h0 && n < 3000) begin
        @(posedge clk_in);
        n++;
      end
      // outputs fall hold cycles after the load, which lands half a bit before send returns
      check("hold span", 1, (n + p / 2 >= HOLD) && (n + p / 2 <= HOLD + 6));
      @(posedge clk_in);
      check("dec asleep", 0, dec_awake);
    end
    report_and_stop();
  end
endmodule // tb_switch_state_link_codec
